// File: verilog/sspf_cfg.svh
// register offsets, field positions, reset values and counts of the serial port
`ifndef SSPF_CFG_SVH
`define SSPF_CFG_SVH
`define SSPF_OFF_CTRL0    8'h00
`define SSPF_OFF_CTRL1    8'h04
`define SSPF_OFF_DATA     8'h08
`define SSPF_OFF_STATUS   8'h0c
`define SSPF_C0_LEN_LSB   0
`define SSPF_C0_LEN_MSB   3
`define SSPF_C0_FMT_LSB   4
`define SSPF_C0_FMT_MSB   5
`define SSPF_C0_IDLE_BIT  6
`define SSPF_C0_PHASE_BIT 7
`define SSPF_C0_DIV_LSB   8
`define SSPF_C0_DIV_MSB   15
`define SSPF_C1_EN_BIT    0
`define SSPF_C1_MST_BIT   1
`define SSPF_CTRL0_RST    16'h0307
`define SSPF_CTRL1_RST    2'h0
`define SSPF_FMT_FSYNC    2'h1
`define SSPF_LEN_MIN_M1   4'h3
`define SSPF_PRE_EDGES    6'h02
`define SSPF_POST_EDGES   6'h04
`endif

// File: verilog/sspf_pkg.sv
// types of the serial port: engine states and the two state records
package sspf_pkg;
  typedef enum logic [1:0] {SSPF_IDLE, SSPF_LEAD, SSPF_RUN, SSPF_TAIL} sspf_state_t;
  typedef struct packed {
    logic [15:0]       cfg0;
    logic [1:0]        cfg1;
    logic [7:0][15:0]  tmem;
    logic [3:0]        twp;
    logic [3:0]        twg;
    logic [3:0]        trg_s1;
    logic [3:0]        trg_s2;
    logic [3:0]        rrp;
    logic [3:0]        rrg;
    logic [3:0]        rwg_s1;
    logic [3:0]        rwg_s2;
    logic [1:0]        bsy_s;
    logic [31:0]       rdata;
  } sspf_bus_t;
  typedef struct packed {
    logic [1:0]        ce_s;
    logic [17:0]       cfg_s1;
    logic [17:0]       cfg_s2;
    logic [3:0]        twg_s1;
    logic [3:0]        twg_s2;
    logic [3:0]        rrg_s1;
    logic [3:0]        rrg_s2;
    logic [3:0]        pin_s1;
    logic [3:0]        pin_s2;
    logic              sck_d;
    sspf_state_t       st;
    logic [5:0]        e;
    logic [7:0]        cnt;
    logic [15:0]       tsh;
    logic [15:0]       rsh;
    logic [3:0]        trp;
    logic [3:0]        trg;
    logic [3:0]        rwp;
    logic [3:0]        rwg;
    logic [7:0][15:0]  rmem;
    logic              sck;
    logic              sel;
    logic              dout;
    logic              doe;
    logic              ctl_oe;
    logic              mosi_oe;
    logic              miso_oe;
    logic              bsy;
  } sspf_link_t;
endpackage : sspf_pkg

// File: verilog/sspf_top.sv
// synchronous serial port: register port, two 8-frame fifos and the four-wire link engine
// What this block does
// - full-duplex frames of 4 to 16 bits
// - separate 8-frame transmit and receive fifos
// - only the master drives the serial clock
// - clock level programmable only in select format
// - serial clock toggles only during a frame
// - select-format master drives select around the data bits
// - slave qualifies data with incoming select
// - slave drives its data only while selected
// - master outputs on one line, samples other
// - frame-sync master idles clock, sync low, tristate
// - frame-sync pulse one period, load shifter
// - msb shifted out on rising after pulse
// - frame-sync data captured on falling edges
// - frame-sync receive word pushed on next rising
// - idle level and phase bits in control zero
// - idle-level bit sets clock resting level
// - phase bit picks first or second capture edge
// - select master idles high, starts on data
`timescale 1ns/1ps
`include "sspf_cfg.svh"
module sspf_top
  import sspf_pkg::*;
(
  // system
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        ce_i,
  input  wire logic        lnk_clk_i,
  // register port
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_we_i,
  input  wire logic        reg_re_i,
  output logic      [31:0] reg_rdata_o,
  // link pins
  input  wire logic        serial_clock_pin_i,
  output logic             serial_clock_pin_o,
  output logic             serial_clock_pin_oe_o,
  input  wire logic        select_frame_pin_i,
  output logic             select_frame_pin_o,
  output logic             select_frame_pin_oe_o,
  input  wire logic        master_to_slave_pin_i,
  output logic             master_to_slave_pin_o,
  output logic             master_to_slave_pin_oe_o,
  input  wire logic        slave_to_master_pin_i,
  output logic             slave_to_master_pin_o,
  output logic             slave_to_master_pin_oe_o
);
  sspf_bus_t  b_ff, nxt_b;
  sspf_link_t l_ff, nxt_l;
  logic       lnk_push;
  logic       tx_full, rx_empty;
  logic [3:0] len_m1;
  logic [4:0] len;
  logic [5:0] len2, d, last_e;
  logic       fs, clock_idle_level_eff, cph, en, mst, din, edge_ev, tick, tx_empty_l, rx_full_l;

  function automatic logic [3:0] sspf_gray(input logic [3:0] bin);
    return bin ^ (bin >> 1);
  endfunction : sspf_gray

  function automatic logic sspf_full(input logic [3:0] wg, input logic [3:0] rg);
    return wg == {~rg[3:2], rg[1:0]};
  endfunction : sspf_full

  // register side
  assign tx_full  = sspf_full(b_ff.twg, b_ff.trg_s2);
  assign rx_empty = b_ff.rrg == b_ff.rwg_s2;
  always_comb
  begin
    nxt_b        = b_ff;
    nxt_b.trg_s1 = l_ff.trg;
    nxt_b.trg_s2 = b_ff.trg_s1;
    nxt_b.rwg_s1 = l_ff.rwg;
    nxt_b.rwg_s2 = b_ff.rwg_s1;
    nxt_b.bsy_s  = {b_ff.bsy_s[0], l_ff.bsy};
    if (ce_i)
    begin
      nxt_b.rdata = 32'h0;
      if (reg_we_i)
      begin
        if (reg_addr_i == `SSPF_OFF_CTRL0)
          nxt_b.cfg0 = reg_wdata_i[15:0];
        else if (reg_addr_i == `SSPF_OFF_CTRL1)
          nxt_b.cfg1 = reg_wdata_i[1:0];
        else if (reg_addr_i == `SSPF_OFF_DATA && !tx_full)
        begin
          nxt_b.tmem[b_ff.twp[2:0]] = reg_wdata_i[15:0];
          nxt_b.twp = b_ff.twp + 4'h1;
          nxt_b.twg = sspf_gray(nxt_b.twp);
        end
      end
      if (reg_re_i)
      begin
        if (reg_addr_i == `SSPF_OFF_CTRL0)
          nxt_b.rdata = {16'h0, b_ff.cfg0};
        else if (reg_addr_i == `SSPF_OFF_CTRL1)
          nxt_b.rdata = {30'h0, b_ff.cfg1};
        else if (reg_addr_i == `SSPF_OFF_DATA && !rx_empty)
        begin
          nxt_b.rdata = {16'h0, l_ff.rmem[b_ff.rrp[2:0]]};
          nxt_b.rrp = b_ff.rrp + 4'h1;
          nxt_b.rrg = sspf_gray(nxt_b.rrp);
        end
        else if (reg_addr_i == `SSPF_OFF_STATUS)
          nxt_b.rdata = {27'h0, b_ff.bsy_s[1], sspf_full(b_ff.rwg_s2, b_ff.rrg), !rx_empty,
                         !tx_full, b_ff.twg == b_ff.trg_s2};
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      b_ff      <= '0;
      b_ff.cfg0 <= `SSPF_CTRL0_RST;
      b_ff.cfg1 <= `SSPF_CTRL1_RST;
    end
    else
      b_ff <= nxt_b;
  end
  assign reg_rdata_o = b_ff.rdata;

  // link side: configuration seen through two flip-flops, resampled every link clock even while a frame runs
  always_comb
  begin
    len_m1   = (l_ff.cfg_s2[3:0] < `SSPF_LEN_MIN_M1) ? `SSPF_LEN_MIN_M1 : l_ff.cfg_s2[3:0];
    len      = {1'b0, len_m1} + 5'h01;
    len2     = {len, 1'b0};
    fs       = l_ff.cfg_s2[5:4] == `SSPF_FMT_FSYNC;
    clock_idle_level_eff = fs ? 1'b0 : l_ff.cfg_s2[6];
    cph      = fs ? 1'b1 : l_ff.cfg_s2[7];
    en       = l_ff.cfg_s2[16];
    mst      = l_ff.cfg_s2[17];
    d        = l_ff.e - (fs ? `SSPF_PRE_EDGES : 6'h00);
    last_e   = fs ? len2 + `SSPF_POST_EDGES - 6'h01 : len2 - 6'h01;
    din      = mst ? l_ff.pin_s2[0] : l_ff.pin_s2[1];
    tick     = l_ff.cnt == 8'h00;
    edge_ev  = (l_ff.st == SSPF_RUN) && (mst ? tick : (l_ff.pin_s2[3] != l_ff.sck_d));
    tx_empty_l = l_ff.trg == l_ff.twg_s2;
    rx_full_l  = sspf_full(l_ff.rwg, l_ff.rrg_s2);
  end

  always_comb
  begin
    nxt_l        = l_ff;
    lnk_push     = 1'b0;
    nxt_l.ce_s   = {l_ff.ce_s[0], ce_i};
    nxt_l.cfg_s1 = {b_ff.cfg1, b_ff.cfg0};
    nxt_l.cfg_s2 = l_ff.cfg_s1;
    nxt_l.twg_s1 = b_ff.twg;
    nxt_l.twg_s2 = l_ff.twg_s1;
    nxt_l.rrg_s1 = b_ff.rrg;
    nxt_l.rrg_s2 = l_ff.rrg_s1;
    nxt_l.pin_s1 = {serial_clock_pin_i, select_frame_pin_i, master_to_slave_pin_i,
                    slave_to_master_pin_i};
    nxt_l.pin_s2 = l_ff.pin_s1;
    nxt_l.sck_d  = l_ff.pin_s2[3];
    if (l_ff.ce_s[1])
    begin
      nxt_l.ctl_oe = en && mst;
      nxt_l.cnt    = (l_ff.st == SSPF_IDLE || tick) ? l_ff.cfg_s2[15:8] : l_ff.cnt - 8'h01;
      case (l_ff.st)
        SSPF_IDLE:
        begin
          nxt_l.sck = clock_idle_level_eff;
          nxt_l.sel = !fs;
          nxt_l.doe = 1'b0;
          if (mst && en && !tx_empty_l)
          begin
            nxt_l.sel = 1'b0;
            nxt_l.doe = !fs;
            nxt_l.st  = SSPF_LEAD;
          end
          else if (!mst && en && !fs && !l_ff.pin_s2[2])
          begin
            nxt_l.doe = 1'b1;
            nxt_l.st  = SSPF_RUN;
          end
          else if (!mst && en && fs && l_ff.sck_d && !l_ff.pin_s2[3] && l_ff.pin_s2[2])
          begin
            nxt_l.st = SSPF_RUN;
          end
          if (nxt_l.st != SSPF_IDLE)
          begin
            nxt_l.e   = (!mst && fs) ? `SSPF_PRE_EDGES : 6'h00;
            nxt_l.rsh = 16'h0;
            nxt_l.tsh = tx_empty_l ? 16'h0 : b_ff.tmem[l_ff.trp[2:0]];
            if (!tx_empty_l)
            begin
              nxt_l.trp = l_ff.trp + 4'h1;
              nxt_l.trg = sspf_gray(nxt_l.trp);
            end
          end
        end
        SSPF_LEAD:
        begin
          if (tick)
            nxt_l.st = SSPF_RUN;
        end
        SSPF_RUN:
        begin
          if (!en || (!mst && !fs && l_ff.pin_s2[2]))
          begin
            nxt_l.st  = SSPF_IDLE;
            nxt_l.doe = 1'b0;
          end
          else if (edge_ev)
          begin
            if (mst)
              nxt_l.sck = !l_ff.sck;
            if (mst && fs && l_ff.e == 6'h00)
              nxt_l.sel = 1'b1;
            if (mst && fs && l_ff.e == `SSPF_PRE_EDGES)
              nxt_l.sel = 1'b0;
            if (d < len2 && l_ff.e >= (fs ? `SSPF_PRE_EDGES : 6'h00))
            begin
              if (d == 6'h00)
                nxt_l.doe = 1'b1;
              if (d[0] == cph)
                nxt_l.rsh = {l_ff.rsh[14:0], din};
              else if (d != 6'h00)
                nxt_l.tsh = {l_ff.tsh[14:0], 1'b0};
            end
            lnk_push = fs ? (d == len2) : (d == len2 - 6'h01);
            if (lnk_push && !rx_full_l)
            begin
              nxt_l.rmem[l_ff.rwp[2:0]] = nxt_l.rsh;
              nxt_l.rwp = l_ff.rwp + 4'h1;
              nxt_l.rwg = sspf_gray(nxt_l.rwp);
            end
            nxt_l.e = l_ff.e + 6'h01;
            if (l_ff.e == last_e)
            begin
              nxt_l.st = mst ? SSPF_TAIL : SSPF_IDLE;
              if (fs)
                nxt_l.doe = 1'b0;
            end
          end
        end
        default:
        begin
          if (tick)
          begin
            nxt_l.st  = SSPF_IDLE;
            nxt_l.sel = !fs;
            nxt_l.doe = 1'b0;
          end
        end
      endcase
      nxt_l.dout    = nxt_l.tsh[len_m1];
      nxt_l.mosi_oe = mst && nxt_l.doe;
      nxt_l.miso_oe = !mst && nxt_l.doe;
      nxt_l.bsy     = nxt_l.st != SSPF_IDLE;
    end
  end

  always_ff @(posedge lnk_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      l_ff <= '0;
    else
      l_ff <= nxt_l;
  end

  // pins; the one shifter bit feeds whichever data line this end owns
  assign serial_clock_pin_o       = l_ff.sck;
  assign serial_clock_pin_oe_o    = l_ff.ctl_oe;
  assign select_frame_pin_o       = l_ff.sel;
  assign select_frame_pin_oe_o    = l_ff.ctl_oe;
  assign master_to_slave_pin_o    = l_ff.dout;
  assign master_to_slave_pin_oe_o = l_ff.mosi_oe;
  assign slave_to_master_pin_o    = l_ff.dout;
  assign slave_to_master_pin_oe_o = l_ff.miso_oe;

  sequence s_fs_rise;
    $rose(select_frame_pin_o) && fs && mst;
  endsequence

  a_sck_idle_level: assert property (
    @(posedge lnk_clk_i) disable iff (!rst_n_i)
    (l_ff.st == SSPF_IDLE && $past(l_ff.st) == SSPF_IDLE && $stable(l_ff.cfg_s2) && mst)
      |-> serial_clock_pin_o == clock_idle_level_eff)
    else $error("serial clock not at idle level");
  a_fs_idle_low: assert property (
    @(posedge lnk_clk_i) disable iff (!rst_n_i)
    (fs && mst && l_ff.st == SSPF_IDLE && $past(l_ff.st) == SSPF_IDLE && $stable(l_ff.cfg_s2))
      |-> !select_frame_pin_o && !master_to_slave_pin_oe_o)
    else $error("frame-sync master not quiet when idle");
  a_sel_idle_high: assert property (
    @(posedge lnk_clk_i) disable iff (!rst_n_i)
    (!fs && mst && l_ff.st == SSPF_IDLE && $past(l_ff.st) == SSPF_IDLE && $stable(l_ff.cfg_s2))
      |-> select_frame_pin_o)
    else $error("select not high while idle");
  a_miso_hiz: assert property (
    @(posedge lnk_clk_i) disable iff (!rst_n_i)
    (!mst && !fs && l_ff.ce_s[1] && l_ff.pin_s2[2] && $stable(l_ff.cfg_s2))
      |=> !slave_to_master_pin_oe_o)
    else $error("slave drives data while deselected");
  a_fs_pulse_open: assert property (
    @(posedge lnk_clk_i) disable iff (!rst_n_i)
    s_fs_rise |-> l_ff.e == 6'h01 ##0 select_frame_pin_o [*1])
    else $error("frame sync rose off the first edge");
  a_fs_pulse_close: assert property (
    @(posedge lnk_clk_i) disable iff (!rst_n_i)
    ($fell(select_frame_pin_o) && fs && mst && l_ff.st == SSPF_RUN) |-> l_ff.e == 6'h03)
    else $error("frame sync pulse not one clock period");
  a_sck_in_frame: assert property (
    @(posedge lnk_clk_i) disable iff (!rst_n_i)
    (mst && $changed(serial_clock_pin_o) && $stable(l_ff.cfg_s2)) |-> $past(l_ff.st) == SSPF_RUN)
    else $error("serial clock moved outside a frame");
  a_rx_push_rise: assert property (
    @(posedge lnk_clk_i) disable iff (!rst_n_i)
    (lnk_push && fs && mst) |=> serial_clock_pin_o)
    else $error("receive word not pushed on a rising edge");
  a_frame_bits: assert property (
    @(posedge lnk_clk_i) disable iff (!rst_n_i)
    (l_ff.st == SSPF_TAIL && $past(l_ff.st) == SSPF_RUN)
      |-> l_ff.e == (fs ? len2 + `SSPF_POST_EDGES : len2))
    else $error("frame edge count wrong");
  a_tx_full_hold: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (ce_i && reg_we_i && reg_addr_i == `SSPF_OFF_DATA && tx_full) |=> $stable(b_ff.twp))
    else $error("write accepted into a full transmit fifo");
endmodule : sspf_top

// File: verification/sspf_far_slave.sv
// behavioural off-chip slave of the serial link, select or frame-sync format
`timescale 1ns/1ps
module sspf_far_slave (
  // link
  input  wire logic        sck_i,
  input  wire logic        sel_i,
  input  wire logic        mosi_i,
  output logic             miso_o,
  // mode
  input  wire logic [3:0]  lm1_i,
  input  wire logic        clock_idle_level_i,
  input  wire logic        clock_capture_phase_i,
  input  wire logic        fsync_i,
  input  wire logic [15:0] base_i,
  // result
  output logic [15:0]      rx_o,
  output int               nfr_o
);
  logic        act = 1'b0;
  logic        cap;
  logic [15:0] tsh;
  logic [15:0] rsh;
  logic [4:0]  idx;
  logic [4:0]  cnt;
  initial miso_o = 1'b0;
  initial nfr_o = 0;
  initial rx_o = 16'h0;
  task start;
    tsh = base_i ^ 16'(nfr_o);
    cnt = 5'h00;
    idx = 5'(lm1_i) + 5'h01;
    act = 1'b1;
  endtask : start
  task shift;
    if (idx != 5'h00)
    begin
      idx = idx - 5'h01;
      miso_o = tsh[idx[3:0]];
    end
  endtask : shift
  // phase 0 puts the msb out as soon as select falls
  always @(negedge sel_i)
    if (!fsync_i)
    begin
      start();
      if (!clock_capture_phase_i)
        shift();
    end
  // released line shows the inverse so a stale bit never looks valid
  always @(posedge sel_i)
    if (!fsync_i)
    begin
      act = 1'b0;
      miso_o = ~miso_o;
    end
  always @(sck_i)
  begin
    cap = fsync_i ? !sck_i : ((sck_i != clock_idle_level_i) ^ clock_capture_phase_i);
    if (act && cap)
    begin
      rsh = {rsh[14:0], mosi_i};
      cnt = cnt + 5'h01;
      if (cnt > 5'(lm1_i))
      begin
        rx_o = rsh & ((16'h1 << (5'(lm1_i) + 5'h1)) - 16'h1);
        nfr_o = nfr_o + 1;
        act = 1'b0;
        if (fsync_i)
          miso_o = ~miso_o;
      end
    end
    else if (act)
      shift();
    if (fsync_i && !sck_i && sel_i && !act)
      start();
  end
endmodule : sspf_far_slave

// File: verification/tb_top.sv
// testbench: serial port as master against the behavioural slave
`timescale 1ns/1ps
`include "sspf_cfg.svh"
module tb_top;
  logic        clk_i = 1'b0;
  logic        lnk_clk_i = 1'b0;
  logic        rst_n_i;
  logic        reg_we_i;
  logic        reg_re_i;
  logic [7:0]  reg_addr_i;
  logic [31:0] reg_wdata_i;
  logic [31:0] reg_rdata_o;
  logic        sck_o, sck_oe, sel_o, sel_oe, mosi_o, mosi_oe, miso_o, miso_oe, far_miso;
  logic        mosi_q = 1'b0;
  logic        clock_idle_level = 1'b0;
  logic        clock_capture_phase = 1'b0;
  logic        fsy = 1'b0;
  logic [3:0]  lm1 = 4'h3;
  logic [15:0] base = 16'hc3a5;
  logic [15:0] msk;
  logic [15:0] rx_far;
  logic [31:0] d;
  int          nfr;
  int          k;
  int          n_fail = 0;
  int          checks = 0;
  // undriven wires rest at their idle level, data at the inverse of its last bit
  wire sck_w  = sck_oe ? sck_o : clock_idle_level;
  wire sel_w  = sel_oe ? sel_o : ~fsy;
  wire mosi_w = mosi_oe ? mosi_o : ~mosi_q;
  wire miso_w = miso_oe ? miso_o : far_miso;
  initial forever #50 clk_i = ~clk_i;
  initial
  begin
    #3;
    forever #7.5 lnk_clk_i = ~lnk_clk_i;
  end
  always @(posedge lnk_clk_i) if (mosi_oe) mosi_q <= mosi_o;
  sspf_top sspf_top_i (.clk_i, .rst_n_i, .ce_i(1'b1), .lnk_clk_i, .reg_addr_i, .reg_wdata_i,
    .reg_we_i, .reg_re_i, .reg_rdata_o, .serial_clock_pin_i(sck_w), .serial_clock_pin_o(sck_o),
    .serial_clock_pin_oe_o(sck_oe), .select_frame_pin_i(sel_w), .select_frame_pin_o(sel_o),
    .select_frame_pin_oe_o(sel_oe), .master_to_slave_pin_i(mosi_w),
    .master_to_slave_pin_o(mosi_o), .master_to_slave_pin_oe_o(mosi_oe),
    .slave_to_master_pin_i(miso_w), .slave_to_master_pin_o(miso_o),
    .slave_to_master_pin_oe_o(miso_oe));
  sspf_far_slave sspf_far_slave_i (.sck_i(sck_w), .sel_i(sel_w), .mosi_i(mosi_w),
    .miso_o(far_miso), .lm1_i(lm1), .clock_idle_level_i(clock_idle_level), .clock_capture_phase_i(clock_capture_phase), .fsync_i(fsy),
    .base_i(base), .rx_o(rx_far), .nfr_o(nfr));
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= v;
    reg_we_i <= 1'b1;
    @(posedge clk_i);
    reg_we_i <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_re_i <= 1'b1;
    @(posedge clk_i);
    reg_re_i <= 1'b0;
    #1 v = reg_rdata_o;
  endtask : rd
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // polls status until the slave saw t frames and the engine is idle with data in
  task wait_frames(input int t);
    int i;
    d = 'x;
    for (i = 0; i < 400 && (nfr < t || d[4] !== 1'b0 || d[2] !== 1'b1); i++)
      rd(`SSPF_OFF_STATUS, d);
    chk("frame wait", 32'h1, {31'h0, i < 400});
  endtask : wait_frames
  task summarize;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : summarize
  initial
  begin
    #600000;
    n_fail++;
    $display("CHECK FAILED watchdog expected finish seen timeout");
    summarize();
  end
  initial
  begin
    rst_n_i = 1'b0;
    reg_we_i = 1'b0;
    reg_re_i = 1'b0;
    reg_addr_i = 8'h00;
    reg_wdata_i = 32'h0;
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd(`SSPF_OFF_CTRL0, d); chk("ctrl0 reset", 32'h0307, d);
    rd(`SSPF_OFF_CTRL1, d); chk("ctrl1 reset", 32'h0, d);
    rd(`SSPF_OFF_STATUS, d); chk("status reset", 32'h3, d);
    rd(8'h10, d); chk("unmapped read", 32'h0, d);
    // enabled slave with select at rest: data and clock lines stay released
    wr(`SSPF_OFF_CTRL1, 32'h1);
    repeat (4) @(posedge clk_i);
    chk("slave data oe", 32'h0, {31'h0, miso_oe});
    chk("slave clock oe", 32'h0, {31'h0, sck_oe});
    wr(`SSPF_OFF_CTRL1, 32'h0);
    $display("test reset and slave release done");
    // four select modes then frame-sync, lengths 4 to 16
    for (int m = 0; m < 5; m++)
    begin
      fsy = (m == 4);
      clock_idle_level = m[0] & !fsy;
      clock_capture_phase = m[1];
      lm1 = 4'(3 + 3 * m);
      msk = (16'h1 << (5'(lm1) + 5'h1)) - 16'h1;
      base = base + 16'h1111;
      wr(`SSPF_OFF_CTRL0, {16'h0, 8'h03, clock_capture_phase, clock_idle_level, 1'b0, fsy, lm1});
      k = nfr;
      wr(`SSPF_OFF_DATA, 32'hf0b6 ^ m);
      wr(`SSPF_OFF_DATA, 32'h5a3c ^ m);
      wr(`SSPF_OFF_CTRL1, 32'h3);
      wait_frames(k + 2);
      chk("far rx", {16'h0, (16'h5a3c ^ 16'(m)) & msk}, {16'h0, rx_far});
      rd(`SSPF_OFF_DATA, d); chk("rx word0", {16'h0, (base ^ 16'(k)) & msk}, d);
      rd(`SSPF_OFF_DATA, d); chk("rx word1", {16'h0, (base ^ 16'(k + 1)) & msk}, d);
      chk("idle clock", {31'h0, clock_idle_level}, {31'h0, sck_o});
      chk("idle select", {31'h0, ~fsy}, {31'h0, sel_o});
      chk("idle data oe", 32'h0, {31'h0, mosi_oe});
      wr(`SSPF_OFF_CTRL1, 32'h0);
      $display("test mode %0d done", m);
    end
    // fill the transmit fifo past eight while stopped, then drain both ways
    fsy = 1'b0;
    clock_idle_level = 1'b0;
    clock_capture_phase = 1'b0;
    lm1 = 4'h7;
    wr(`SSPF_OFF_CTRL0, 32'h0307);
    k = nfr;
    for (int i = 0; i < 9; i++)
      wr(`SSPF_OFF_DATA, 32'h40 + i);
    rd(`SSPF_OFF_STATUS, d); chk("status tx full", 32'h0, d);
    wr(`SSPF_OFF_CTRL1, 32'h3);
    wait_frames(k + 8);
    rd(`SSPF_OFF_STATUS, d); chk("status rx full", 32'hf, d);
    chk("far rx last", 32'h47, {16'h0, rx_far});
    for (int i = 0; i < 8; i++)
    begin
      rd(`SSPF_OFF_DATA, d); chk("rx fifo word", {24'h0, base[7:0] ^ 8'(k + i)}, d);
    end
    rd(`SSPF_OFF_DATA, d); chk("rx empty read", 32'h0, d);
    chk("frame count", 32'(k + 8), 32'(nfr));
    $display("test fifo depth done");
    summarize();
  end
endmodule : tb_top
